// file: pkg/ohb_consts.vh
`ifndef OHB_CONSTS_VH
`define OHB_CONSTS_VH
// ==========================================
// register offsets of the controller's own port
`define OHB_A_CTRL 8'h00
`define OHB_A_TXD 8'h04
`define OHB_A_RXD 8'h08
`define OHB_A_STAT 8'h0c
`define OHB_A_ACC 8'h10
`define OHB_A_BPC 8'h14
`define OHB_A_BAUD 8'h18
// ==========================================
// control fields
`define OHB_CTRL_MODE_LO 0
`define OHB_CTRL_MODE_HI 1
`define OHB_CTRL_GO 2
`define OHB_CTRL_REPLY 3
`define OHB_MODE_OFF 2'h0
`define OHB_MODE_TWO_PIN 2'h1
`define OHB_MODE_ONE_WIRE 2'h2
// ==========================================
// status fields
`define OHB_ST_BUSY 0
`define OHB_ST_RXV 1
`define OHB_ST_HALT 2
`define OHB_ST_REF 3
`define OHB_ST_BPERR 4
`define OHB_ST_BAUDV 5
// ==========================================
// access request fields
`define OHB_ACC_WR 16
// ==========================================
// breakpoint setup fields
`define OHB_BP_EN_A0 0
`define OHB_BP_EN_A1 1
`define OHB_BP_EN_V0 2
`define OHB_BP_EN_V1 3
`define OHB_BP_DATA 4
`define OHB_BP_COMBO_LO 5
`define OHB_BP_COMBO_HI 6
`define OHB_BP_SPACE_LO 7
`define OHB_BP_SPACE_HI 8
`define OHB_COMBO_SINGLES 2'h0
`define OHB_COMBO_RANGE 2'h1
`define OHB_COMBO_VALUE 2'h2
`define OHB_COMBO_DATA_RANGE 2'h3
`define OHB_SPACE_BAD 2'h3
// ==========================================
// reset values, event code and timing counts
`define OHB_BPC_RST 9'h000
`define OHB_HALT_EVT 8'he0
`define OHB_TP_HALF 16
`define OHB_SW_BREAK 2000
`endif

// file: core/ohb_baud.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// low pulse width meter for single wire baud detection
module ohb_baud #(
	parameter W = 16
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_arm,
	input wire i_line,
	output reg [W-1:0] o_period,
	output reg o_valid
);
	reg [W-1:0] cnt_ff;
	reg low_ff;
	reg prev_ff;

	// count the first low pulse after arming, latch at its end
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_ff <= {W{1'b0}};
			low_ff <= 1'b0;
			prev_ff <= 1'b1;
			o_period <= {W{1'b0}};
			o_valid <= 1'b0;
		end else begin
			prev_ff <= i_line;
			o_valid <= 1'b0;
			if (!i_arm) begin
				low_ff <= 1'b0;
				cnt_ff <= {W{1'b0}};
			end else if (prev_ff && !i_line) begin
				low_ff <= 1'b1; // start of sync pulse
				cnt_ff <= {{(W-1){1'b0}}, 1'b1};
			end else if (low_ff && !i_line) begin
				if (cnt_ff != {W{1'b1}})
					cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
			end else if (low_ff && i_line) begin
				low_ff <= 1'b0;
				o_period <= cnt_ff;
				o_valid <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: core/ohb_host.v
`include "ohb_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ohb_host #(
	parameter TP_HALF = `OHB_TP_HALF,
	parameter SW_BREAK = `OHB_SW_BREAK,
	parameter BAUD_W = 16,
	parameter [15:0] UART_ADDR = 16'h000c, // arbitrary
	parameter [15:0] SPI_ADDR = 16'h000f, // arbitrary
	parameter [15:0] ROC_ADDR = 16'h0020, // arbitrary
	parameter [15:0] W1C_ADDR = 16'h0038 // arbitrary
) (
	input wire i_clk,
	input wire i_nrst,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	output wire o_tp_clk,
	output wire o_tp_dat,
	output wire o_tp_dat_oe,
	input wire i_tp_dat,
	output wire o_sw_out,
	output wire o_sw_oe,
	input wire i_sw_in,
	output wire o_halted,
	output wire o_busy
);
	localparam [15:0] TPH_M1 = TP_HALF[15:0] - 16'h0001;
	localparam [15:0] BRK_M1 = SW_BREAK[15:0] - 16'h0001;
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_TX = 4'h1;
	localparam [3:0] S_TURN = 4'h2;
	localparam [3:0] S_RX = 4'h3;
	localparam [3:0] S_BRK = 4'h4;
	localparam [3:0] S_SYNC = 4'h5;
	localparam [3:0] S_SWTX = 4'h6;
	localparam [3:0] S_SWWAIT = 4'h7;
	localparam [3:0] S_SWRX = 4'h8;
	localparam [3:0] S_DONE = 4'h9;

	// ==========================================
	// input synchronisers
	reg tp_s1_ff, tp_s2_ff, sw_s1_ff, sw_s2_ff;
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tp_s1_ff <= 1'b1;
			tp_s2_ff <= 1'b1;
			sw_s1_ff <= 1'b1;
			sw_s2_ff <= 1'b1;
		end else begin
			tp_s1_ff <= i_tp_dat;
			tp_s2_ff <= tp_s1_ff;
			sw_s1_ff <= i_sw_in;
			sw_s2_ff <= sw_s1_ff;
		end
	end

	// ==========================================
	// state
	reg [3:0] state_ff, nxt_state;
	reg [1:0] mode_ff;
	reg reply_ff;
	reg [7:0] txd_ff, rxd_ff, sh_ff;
	reg [3:0] bit_ff;
	reg [15:0] div_ff;
	reg tp_clk_ff, tp_dat_ff, tp_oe_ff, sw_oe_ff;
	reg [BAUD_W-1:0] tmr_ff, period_ff;
	reg baud_ok_ff;
	reg rxv_ff, halt_ff, ref_ff, bperr_ff;
	reg [8:0] bpc_ff;
	reg go_pend_ff;
	wire [BAUD_W-1:0] meas;
	wire meas_v;

	// ==========================================
	// decoded bus strokes
	wire wr_ctrl = i_wr && (i_addr == `OHB_A_CTRL);
	wire wr_txd = i_wr && (i_addr == `OHB_A_TXD);
	wire wr_stat = i_wr && (i_addr == `OHB_A_STAT);
	wire wr_acc = i_wr && (i_addr == `OHB_A_ACC);
	wire wr_bpc = i_wr && (i_addr == `OHB_A_BPC);
	wire idle = (state_ff == S_IDLE);
	wire [15:0] acc_a = i_wdata[15:0];
	wire acc_w = i_wdata[`OHB_ACC_WR];

	// access filter against side-effect registers
	wire acc_bad = (acc_a == UART_ADDR) || (acc_a == SPI_ADDR)
		|| (halt_ff && !acc_w && (acc_a == ROC_ADDR))
		|| (halt_ff && acc_w && (acc_a == W1C_ADDR));

	// comparator setup check
	wire [1:0] combo = i_wdata[`OHB_BP_COMBO_HI:`OHB_BP_COMBO_LO];
	wire [1:0] space = i_wdata[`OHB_BP_SPACE_HI:`OHB_BP_SPACE_LO];
	wire is_data = i_wdata[`OHB_BP_DATA];
	wire a0 = i_wdata[`OHB_BP_EN_A0];
	wire a1 = i_wdata[`OHB_BP_EN_A1];
	wire v0 = i_wdata[`OHB_BP_EN_V0];
	wire v1 = i_wdata[`OHB_BP_EN_V1];
	wire none_on = !(a0 || a1 || v0 || v1);
	reg bp_ok;
	// one type bit for all comparators keeps the types from mixing
	always @* begin
		bp_ok = 1'b0;
		case (combo)
			`OHB_COMBO_SINGLES: bp_ok = !v0 && !v1 && (a0 || a1);
			`OHB_COMBO_RANGE: bp_ok = a0 && a1 && !v0 && !v1;
			`OHB_COMBO_VALUE: bp_ok = is_data && a0 && a1 && v0 && !v1;
			`OHB_COMBO_DATA_RANGE: bp_ok = is_data && ((a0 && a1) || (v0 && v1))
				&& !(a0 ^ a1) && !(v0 ^ v1);
			default: bp_ok = 1'b0;
		endcase
		if (is_data && space == `OHB_SPACE_BAD)
			bp_ok = 1'b0;
		if (none_on)
			bp_ok = 1'b1; // disarm all
	end

	// ==========================================
	// register file
	wire start = go_pend_ff && idle;
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_ff <= `OHB_MODE_OFF;
			reply_ff <= 1'b0;
			txd_ff <= 8'h00;
			bpc_ff <= `OHB_BPC_RST;
			bperr_ff <= 1'b0;
			ref_ff <= 1'b0;
			go_pend_ff <= 1'b0;
		end else begin
			if (start)
				go_pend_ff <= 1'b0;
			if (wr_ctrl) begin
				mode_ff <= i_wdata[`OHB_CTRL_MODE_HI:`OHB_CTRL_MODE_LO];
				reply_ff <= i_wdata[`OHB_CTRL_REPLY];
				if (i_wdata[`OHB_CTRL_GO] && idle)
					go_pend_ff <= 1'b1;
			end
			if (wr_txd)
				txd_ff <= i_wdata[7:0];
			// allowed access sends its address byte, refused one is flagged
			if (wr_acc && idle && !acc_bad) begin
				txd_ff <= acc_a[7:0];
				reply_ff <= !acc_w;
				go_pend_ff <= 1'b1;
			end
			if (wr_bpc && bp_ok)
				bpc_ff <= i_wdata[8:0];
			// sticky flags, a new event beats the clear
			if (wr_bpc && !bp_ok)
				bperr_ff <= 1'b1;
			else if (wr_stat && i_wdata[`OHB_ST_BPERR])
				bperr_ff <= 1'b0;
			if (wr_acc && acc_bad)
				ref_ff <= 1'b1;
			else if (wr_stat && i_wdata[`OHB_ST_REF])
				ref_ff <= 1'b0;
		end
	end

	// read data, one cycle after the strobe
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`OHB_A_CTRL: o_rdata <= {28'h0000000, reply_ff, 1'b0, mode_ff};
				`OHB_A_TXD: o_rdata <= {24'h000000, txd_ff};
				`OHB_A_RXD: o_rdata <= {24'h000000, rxd_ff};
				`OHB_A_STAT: o_rdata <= {26'h0000000, baud_ok_ff, bperr_ff, ref_ff,
					halt_ff, rxv_ff, !idle};
				`OHB_A_BPC: o_rdata <= {23'h000000, bpc_ff};
				`OHB_A_BAUD: o_rdata <= {{(32-BAUD_W){1'b0}}, period_ff};
				default: o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

	// ==========================================
	// two-pin clock divider, clock idles high
	wire tick = (div_ff == TPH_M1);
	wire fall = tick && tp_clk_ff;
	wire rise = tick && !tp_clk_ff;
	wire tp_run = (state_ff == S_TX) || (state_ff == S_TURN) || (state_ff == S_RX);
	wire tmr_end = (tmr_ff == {BAUD_W{1'b0}});
	wire [BAUD_W-1:0] half = {1'b0, period_ff[BAUD_W-1:1]};
	wire sw_arm = (state_ff == S_SYNC);

	// ==========================================
	// transfer sequencer
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: if (start) begin
				if (mode_ff == `OHB_MODE_TWO_PIN)
					nxt_state = S_TX;
				else if (mode_ff == `OHB_MODE_ONE_WIRE)
					nxt_state = baud_ok_ff ? S_SWTX : S_BRK;
			end
			S_TX: if (rise && bit_ff == 4'h7)
				nxt_state = reply_ff ? S_TURN : S_DONE;
			S_TURN: if (fall)
				nxt_state = S_RX;
			S_RX: if (rise && bit_ff == 4'h7)
				nxt_state = S_DONE;
			S_BRK: if (tmr_end)
				nxt_state = S_SYNC;
			S_SYNC: if (meas_v)
				nxt_state = S_SWTX;
			S_SWTX: if (tmr_end && bit_ff == 4'h9)
				nxt_state = reply_ff ? S_SWWAIT : S_DONE;
			S_SWWAIT: if (!sw_s2_ff)
				nxt_state = S_SWRX;
			S_SWRX: if (tmr_end && bit_ff == 4'h9)
				nxt_state = S_DONE;
			S_DONE: nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	// datapath of both links
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= S_IDLE;
			div_ff <= 16'h0000;
			tp_clk_ff <= 1'b1;
			tp_dat_ff <= 1'b1;
			tp_oe_ff <= 1'b0;
			sw_oe_ff <= 1'b0;
			sh_ff <= 8'h00;
			bit_ff <= 4'h0;
			tmr_ff <= {BAUD_W{1'b0}};
			period_ff <= {BAUD_W{1'b0}};
			baud_ok_ff <= 1'b0;
			rxd_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (tp_run) begin
				div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
				if (tick)
					tp_clk_ff <= !tp_clk_ff;
			end else begin
				div_ff <= 16'h0000;
				tp_clk_ff <= 1'b1;
			end
			if (!tmr_end)
				tmr_ff <= tmr_ff - {{(BAUD_W-1){1'b0}}, 1'b1};
			if (mode_ff != `OHB_MODE_ONE_WIRE)
				baud_ok_ff <= 1'b0;
			case (state_ff)
				S_IDLE: begin
					sh_ff <= txd_ff;
					bit_ff <= 4'h0;
					tp_oe_ff <= 1'b0;
					sw_oe_ff <= 1'b0;
					if (nxt_state == S_BRK)
						tmr_ff <= BRK_M1[BAUD_W-1:0];
					if (nxt_state == S_SWTX) begin
						sw_oe_ff <= 1'b1; // start bit
						tmr_ff <= period_ff;
					end
				end
				// data changes on falling edges, target samples on rising
				S_TX: begin
					if (fall) begin
						tp_dat_ff <= sh_ff[0];
						tp_oe_ff <= 1'b1;
						sh_ff <= {1'b0, sh_ff[7:1]};
					end
					if (rise)
						bit_ff <= bit_ff + 4'h1;
				end
				S_TURN: begin
					bit_ff <= 4'h0;
					if (fall)
						tp_oe_ff <= 1'b0;
				end
				S_RX: if (rise) begin
					sh_ff <= {tp_s2_ff, sh_ff[7:1]};
					bit_ff <= bit_ff + 4'h1;
					if (bit_ff == 4'h7)
						rxd_ff <= {tp_s2_ff, sh_ff[7:1]};
				end
				// break low, then release and time the sync pulse
				S_BRK: sw_oe_ff <= 1'b1;
				S_SYNC: begin
					sw_oe_ff <= 1'b0;
					if (meas_v) begin
						period_ff <= meas;
						baud_ok_ff <= 1'b1;
						tmr_ff <= meas;
						sw_oe_ff <= 1'b1;
					end
				end
				// open-drain frame: start, eight data bits, stop
				S_SWTX: if (tmr_end) begin
					tmr_ff <= period_ff;
					bit_ff <= bit_ff + 4'h1;
					if (bit_ff < 4'h8) begin
						sw_oe_ff <= !sh_ff[0];
						sh_ff <= {1'b0, sh_ff[7:1]};
					end else begin
						sw_oe_ff <= 1'b0;
					end
				end
				S_SWWAIT: begin
					sw_oe_ff <= 1'b0;
					bit_ff <= 4'h0;
					tmr_ff <= half + period_ff; // centre of bit 0
				end
				S_SWRX: if (tmr_end) begin
					tmr_ff <= period_ff;
					bit_ff <= bit_ff + 4'h1;
					if (bit_ff < 4'h8)
						sh_ff <= {sw_s2_ff, sh_ff[7:1]};
					if (bit_ff == 4'h8)
						rxd_ff <= sh_ff;
				end
				S_DONE: begin
					tp_oe_ff <= 1'b0;
					sw_oe_ff <= 1'b0;
				end
				default: begin
					tp_oe_ff <= 1'b0;
					sw_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// reply flags and halt event
	wire got = (state_ff == S_DONE) && reply_ff;
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rxv_ff <= 1'b0;
			halt_ff <= 1'b0;
		end else begin
			if (got)
				rxv_ff <= 1'b1;
			else if (wr_stat && i_wdata[`OHB_ST_RXV])
				rxv_ff <= 1'b0;
			if (got && rxd_ff == `OHB_HALT_EVT)
				halt_ff <= 1'b1;
			else if (wr_stat && i_wdata[`OHB_ST_HALT])
				halt_ff <= 1'b0;
		end
	end

	// ==========================================
	// baud meter and pins
	ohb_baud #(
		.W(BAUD_W)
	) u_baud (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_arm(sw_arm),
		.i_line(sw_s2_ff),
		.o_period(meas),
		.o_valid(meas_v)
	);

	assign o_tp_clk = tp_clk_ff;
	assign o_tp_dat = tp_dat_ff;
	assign o_tp_dat_oe = tp_oe_ff;
	assign o_sw_out = 1'b0; // only ever pulls low
	assign o_sw_oe = sw_oe_ff;
	assign o_halted = halt_ff;
	assign o_busy = !idle;
endmodule
`default_nettype wire

// file: tb/ohb_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ohb_consts.vh"
// ==========================================
// port checker for the debug link host
module ohb_host_properties #(
	parameter int TP_HALF = 4,
	parameter logic [15:0] UART_ADDR = 16'h0000,
	parameter logic [15:0] SPI_ADDR = 16'h0000,
	parameter logic [15:0] ROC_ADDR = 16'h0000,
	parameter logic [15:0] W1C_ADDR = 16'h0000
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_tp_clk,
	input wire logic o_tp_dat,
	input wire logic o_tp_dat_oe,
	input wire logic i_tp_dat,
	input wire logic o_sw_out,
	input wire logic o_sw_oe,
	input wire logic i_sw_in,
	input wire logic o_halted,
	input wire logic o_busy
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	// read data only stand in the cycle after a read strobe
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside a read answer");
	// the single wire is only ever pulled low
	a_sw_drive_low: assert property (o_sw_out == 1'b0)
		else $error("single wire driven high");
	// the single wire is only pulled during a transfer
	a_sw_pull_busy: assert property (o_sw_oe |-> o_busy)
		else $error("single wire pulled while idle");
	// link clock rests high between frames
	a_clk_idle_high: assert property (!o_busy && !$past(o_busy) |-> o_tp_clk)
		else $error("link clock low while idle");
	// host data only moves at a falling link clock edge
	a_dat_at_fall: assert property (o_tp_dat_oe && $past(o_tp_dat_oe) &&
		o_tp_dat != $past(o_tp_dat) |-> $fell(o_tp_clk))
		else $error("link data moved away from falling edge");
	// low half of the link clock lasts the set count
	a_clk_half: assert property ($fell(o_tp_clk) |-> ##TP_HALF $rose(o_tp_clk))
		else $error("link clock low phase length wrong");
	// a go order on the two-pin link starts a frame
	a_busy_start: assert property (i_wr && i_addr == `OHB_A_CTRL && i_wdata[2] &&
		i_wdata[1:0] == `OHB_MODE_TWO_PIN && !o_busy |-> ##[1:2] o_busy)
		else $error("frame did not start");
	// serial data registers are never touched
	a_refuse_port: assert property (i_wr && i_addr == `OHB_A_ACC && !o_busy &&
		(i_wdata[15:0] == UART_ADDR || i_wdata[15:0] == SPI_ADDR) |=> !o_busy [*4])
		else $error("access to serial data register sent");
	// side effect registers are left alone while halted
	a_refuse_halt: assert property (i_wr && i_addr == `OHB_A_ACC && o_halted &&
		!o_busy && ((!i_wdata[16] && i_wdata[15:0] == ROC_ADDR) ||
		(i_wdata[16] && i_wdata[15:0] == W1C_ADDR)) |=> !o_busy [*4])
		else $error("forbidden access sent while halted");
	// status halt bit and halt output agree
	a_halt_status: assert property ($past(i_rd) && $past(i_addr) == `OHB_A_STAT |->
		o_rdata[`OHB_ST_HALT] == $past(o_halted))
		else $error("halt bit and halt output differ");
endmodule
bind ohb_host ohb_host_properties #(.TP_HALF(TP_HALF), .UART_ADDR(UART_ADDR),
	.SPI_ADDR(SPI_ADDR), .ROC_ADDR(ROC_ADDR), .W1C_ADDR(W1C_ADDR)) ohb_host_properties_inst (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_tp_clk(o_tp_clk), .o_tp_dat(o_tp_dat),
	.o_tp_dat_oe(o_tp_dat_oe), .i_tp_dat(i_tp_dat), .o_sw_out(o_sw_out), .o_sw_oe(o_sw_oe),
	.i_sw_in(i_sw_in), .o_halted(o_halted), .o_busy(o_busy));
`default_nettype wire

// file: tb/ohb_tgt_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ohb_consts.vh"
// ==========================================
// target side of both debug links
module ohb_tgt_model #(
	parameter logic [7:0] BRK_CMD = 8'h42,
	parameter int SYNC = 40,
	parameter int BRK_MIN = 500,
	parameter int SW_BIT = SYNC + 1, // host bit is its measured period plus one
	parameter int N_CMP = 4,
	parameter bit FROZEN = 1'b1,
	parameter bit TMR_RUN = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_tp_clk,
	input wire logic i_host_dat,
	input wire logic i_host_oe,
	input wire logic i_sw,
	output logic o_dat,
	output logic o_dat_oe,
	output logic [7:0] o_last,
	output logic o_sw_oe
);
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'h00;
	int rc = 0;
	int tc = 8;
	int lowc = 0;
	int cnt = 0;
	int sw_t = -1;
	int j;
	logic sw_ok = 1'b0;
	logic sw_prev = 1'b1;
	logic sw_pull = 1'b0;
	logic [7:0] sw_rx = 8'h00;
	logic [9:0] fr;
	// halted core: refresh pinned low, I/O frozen or running by variant, watchdog held
	logic halted = 1'b0;
	wire [7:0] refresh = halted ? 8'h10 : 8'h80; // running value arbitrary
	wire io_run = !(halted && FROZEN);
	wire tmr_run = !halted || (!FROZEN && TMR_RUN);
	wire wdt_run = !halted;
	initial begin
		o_dat = 1'b1;
		o_dat_oe = 1'b0;
		o_last = 8'h00;
		o_sw_oe = 1'b0;
	end
	// reset pin is the link clock; the halted core runs from it
	always @(posedge i_tp_clk) begin
		if (i_host_oe) begin
			sh = {i_host_dat, sh[7:1]};
			tc = 8;
			rc++;
			if (rc == 8) begin
				rc = 0;
				o_last = sh;
				tx = (sh == BRK_CMD) ? `OHB_HALT_EVT : ~sh;
				halted = halted || (sh == BRK_CMD);
				tc = 0;
			end
		end else if (tc == 8) begin
			o_dat_oe = 1'b0; // let go after the last reply bit
		end
	end
	// reply bits after each falling edge once the host lets go
	always @(negedge i_tp_clk) begin
		#1;
		if (!i_host_oe && tc < 8) begin
			o_dat = tx[tc];
			o_dat_oe = 1'b1;
			tc++;
		end else if (i_host_oe) begin
			o_dat_oe = 1'b0;
		end
	end
	// a long break is answered by one low sync pulse of SYNC cycles
	always @(posedge i_clk) begin
		o_sw_oe <= ((cnt > 0) && (cnt <= SYNC)) || sw_pull;
		if (cnt > 0) begin
			cnt--;
			if (cnt == 0)
				sw_ok = 1'b1;
		end else if (!i_sw) begin
			lowc++;
		end else begin
			if (lowc >= BRK_MIN) cnt = SYNC + 8;
			lowc = 0;
		end
	end
	// single wire: time the host frame from its start bit, sample mid-bit, answer inverted
	always @(posedge i_clk) begin
		fr = {1'b1, ~sw_rx, 1'b0};
		j = (sw_t - 11 * SW_BIT) / SW_BIT;
		sw_pull <= (sw_t >= 11 * SW_BIT) && (j < 10) && !fr[j];
		if (sw_t > SW_BIT && sw_t < 9 * SW_BIT && sw_t % SW_BIT == SW_BIT / 2)
			sw_rx = {i_sw, sw_rx[7:1]};
		if (sw_t >= 21 * SW_BIT)
			sw_t = -1;
		else if (sw_t >= 0)
			sw_t++;
		else if (sw_ok && sw_prev && !i_sw)
			sw_t = 0;
		sw_prev = i_sw;
	end
endmodule
`default_nettype wire

// file: tb/ohb_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ohb_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module ohb_host_tb;
	localparam int SYNC = 40;
	localparam logic [15:0] RA = 16'h0020;
	// breakpoint setups, bit 9 marks one to be refused
	localparam logic [9:0] ROWS [11] = '{10'h003, 10'h206, 10'h023, 10'h221, 10'h0d7,
		10'h2df, 10'h17c, 10'h371, 10'h3d7, 10'h247, 10'h000};
	// forbidden accesses: write flag and target address
	localparam logic [16:0] BADS [4] = '{17'h0000c, 17'h1000f, 17'h00020, 17'h10038};
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	wire [31:0] o_rdata;
	wire o_tp_clk, o_tp_dat, o_tp_dat_oe, o_sw_out, o_sw_oe, o_halted, o_busy;
	logic m_dat, m_oe, m_swoe;
	logic [7:0] m_last;
	logic [31:0] d, prev;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int i;
	// data wire: host, else target, else a level that keeps moving
	wire tp_dat = o_tp_dat_oe ? o_tp_dat : (m_oe ? m_dat : i_clk);
	wire sw_line = !(o_sw_oe || m_swoe);
	ohb_host #(.TP_HALF(4), .SW_BREAK(1000), .UART_ADDR(16'h000c), .SPI_ADDR(16'h000f),
		.ROC_ADDR(RA), .W1C_ADDR(16'h0038)) ohb_host_inst (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_tp_clk(o_tp_clk), .o_tp_dat(o_tp_dat), .o_tp_dat_oe(o_tp_dat_oe),
		.i_tp_dat(tp_dat), .o_sw_out(o_sw_out), .o_sw_oe(o_sw_oe), .i_sw_in(sw_line),
		.o_halted(o_halted), .o_busy(o_busy));
	ohb_tgt_model #(.SYNC(SYNC)) ohb_tgt_model_inst (.i_clk(i_clk), .i_tp_clk(o_tp_clk),
		.i_host_dat(o_tp_dat), .i_host_oe(o_tp_dat_oe), .i_sw(sw_line), .o_dat(m_dat),
		.o_dat_oe(m_oe), .o_last(m_last), .o_sw_oe(m_swoe));
	initial forever #2.5 i_clk = ~i_clk;
	// register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask
	task automatic idle(input int n);
		int k;
		repeat (3) @(negedge i_clk);
		for (k = 0; k < n && o_busy !== 1'b0; k++) @(negedge i_clk);
		`CHK("busy", 1'b0, o_busy)
	endtask
	task automatic rst_chk();
		`CHK("tp_clk", 1'b1, o_tp_clk)
		`CHK("tp_oe", 1'b0, o_tp_dat_oe)
		`CHK("sw_oe", 1'b0, o_sw_oe)
		`CHK("halted", 1'b0, o_halted)
		`CHK("busy", 1'b0, o_busy)
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge i_clk);
		@(negedge i_clk);
		rst_chk();
		@(posedge i_clk);
		i_nrst <= 1'b1;
		rd(`OHB_A_BPC);
		`CHK("bpcfg_rst", {23'h0, `OHB_BPC_RST}, d)
		rd(`OHB_A_STAT);
		`CHK("status_rst", 32'h0, d)
		wr(8'h1c, 32'hffffffff);
		rd(8'h1c);
		`CHK("unmapped", 32'h0, d)
		prev = 32'h0;
		// accepted setups read back, refused ones keep the old setup
		for (i = 0; i < 11; i++) begin
			wr(`OHB_A_BPC, {23'h0, ROWS[i][8:0]});
			rd(`OHB_A_STAT);
			`CHK("bp_err", ROWS[i][9], d[`OHB_ST_BPERR])
			if (!ROWS[i][9]) prev = {23'h0, ROWS[i][8:0]};
			rd(`OHB_A_BPC);
			`CHK("bpcfg", prev, d)
			wr(`OHB_A_STAT, 32'h10);
		end
		// two-pin frame with a reply
		wr(`OHB_A_CTRL, 32'h1);
		wr(`OHB_A_TXD, 32'ha5);
		wr(`OHB_A_CTRL, 32'hd);
		idle(400);
		`CHK("tgt_rx", 8'ha5, m_last)
		rd(`OHB_A_RXD);
		`CHK("rxd", 32'h5a, d)
		rd(`OHB_A_STAT);
		`CHK("rx_valid", 1'b1, d[`OHB_ST_RXV])
		rd(`OHB_A_CTRL);
		`CHK("ctrl", 32'h9, d)
		rd(`OHB_A_TXD);
		`CHK("txd", 32'ha5, d)
		// access read whose reply is the halt event
		wr(`OHB_A_ACC, 32'h42);
		idle(400);
		`CHK("halted", 1'b1, o_halted)
		rd(`OHB_A_RXD);
		`CHK("halt_evt", {24'h0, `OHB_HALT_EVT}, d)
		// forbidden accesses are flagged and nothing goes out
		for (i = 0; i < 4; i++) begin
			wr(`OHB_A_STAT, 32'h8);
			wr(`OHB_A_ACC, {15'h0, BADS[i]});
			idle(10);
			rd(`OHB_A_STAT);
			`CHK("refused", 1'b1, d[`OHB_ST_REF])
			`CHK("no_frame", 8'h42, m_last)
		end
		wr(`OHB_A_STAT, 32'h4);
		@(negedge i_clk);
		`CHK("resumed", 1'b0, o_halted)
		wr(`OHB_A_ACC, {16'h0, RA});
		idle(400);
		`CHK("roc_sent", 8'h20, m_last)
		// single wire: break, measured sync pulse, then a frame
		wr(`OHB_A_CTRL, 32'h2);
		wr(`OHB_A_CTRL, 32'he);
		idle(4000);
		rd(`OHB_A_RXD);
		`CHK("sw_reply", {24'h0, ~RA[7:0]}, d)
		rd(`OHB_A_STAT);
		`CHK("baud_known", 1'b1, d[`OHB_ST_BAUDV])
		rd(`OHB_A_BAUD);
		`CHK("baud", 1'b1, d >= SYNC && d <= SYNC + 3)
		// second reset mid-run clears the reply valid and refused flags and forgets the baud
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (3) @(negedge i_clk);
		rst_chk();
		@(posedge i_clk);
		i_nrst <= 1'b1;
		rd(`OHB_A_STAT);
		`CHK("status_rst2", 32'h0, d)
		give_verdict();
	end
endmodule
`default_nettype wire
